/* gpb_bank.sv */
// gpb_bank: port g data and function logic, port a/b pin interrupts
// assumes a same-clock register master; pins are asynchronous
//
// Behaviour
// R1: input pin reads back sampled pin level
// R2: output pin reads back stored data bit
// R3: output pin drives stored data level
// R4: mode 00 in, 10 out, 11 alt2
// R5: five two-bit mode fields, bits 9..0
// R6: software never writes 0x0c10 to 0x0c16
// R7: software never writes 0x0c1c to 0x0c22
// R8: port b type bit: level or edge
// R9: port a type bit: level or edge
// R10: port b polarity: high/rising or low/falling
// R11: port a polarity: high/rising or low/falling
// R12: software clears status before changing trigger
// R13: port b enable bits gate interrupt generation
// R14: software configures trigger before enabling pin
// R15: enabled trigger condition sets status bit
// R16: reserved bits 11..8 reset to zero
// R17: port a enable bits gate interrupt generation
// R18: status bit clears on one then zero
// R19: synchronise pins, merge status into irq
`timescale 1ns/100ps
module gpb_bank
  import gpb_pkg::*;
#(
  parameter int G_PINS = 5,
  parameter int IRQ_PINS = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [DATA_W-1:0] rd_data,
  // port g pins
  input wire logic [G_PINS-1:0] port_g_pins_in,
  output logic [G_PINS-1:0] port_g_pins_out,
  output logic [G_PINS-1:0] port_g_pins_oe,
  // second alternate function
  input wire logic [G_PINS-1:0] alt2_out,
  input wire logic [G_PINS-1:0] alt2_oe,
  output logic [G_PINS-1:0] alt2_in,
  // port a and b pins 7..4
  input wire logic [IRQ_PINS-1:0] port_a_pins_in,
  input wire logic [IRQ_PINS-1:0] port_b_pins_in,
  // interrupt
  output logic irq
);

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  logic [G_PINS-1:0] g_sync1;
  logic [G_PINS-1:0] g_sync2;
  logic [IRQ_PINS-1:0] a_sync1;
  logic [IRQ_PINS-1:0] a_sync2;
  logic [IRQ_PINS-1:0] a_prev;
  logic [IRQ_PINS-1:0] b_sync1;
  logic [IRQ_PINS-1:0] b_sync2;
  logic [IRQ_PINS-1:0] b_prev;

  // R19: two-stage pin sync
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      g_sync1 <= '0;
      g_sync2 <= '0;
      a_sync1 <= '0;
      a_sync2 <= '0;
      a_prev <= '0;
      b_sync1 <= '0;
      b_sync2 <= '0;
      b_prev <= '0;
    end else begin
      g_sync1 <= port_g_pins_in;
      g_sync2 <= g_sync1;
      a_sync1 <= port_a_pins_in;
      a_sync2 <= a_sync1;
      a_prev <= a_sync2;
      b_sync1 <= port_b_pins_in;
      b_sync2 <= b_sync1;
      b_prev <= b_sync2;
    end
  end

  // ***************************************************
  // port g pin decode
  // ***************************************************
  logic [G_PINS-1:0] g_data;
  logic [2*G_PINS-1:0] g_func;
  logic [G_PINS-1:0] g_is_out;
  logic [G_PINS-1:0] g_is_alt;
  logic [G_PINS-1:0] g_rd;
  logic [G_PINS-1:0] g_out_d;
  logic [G_PINS-1:0] g_oe_d;

  for (genvar i = 0; i < G_PINS; i++) begin : g_pin
    // R4: mode field decode
    assign g_is_out[i] = (g_func[2*i+1 -: 2] == MODE_OUT);
    assign g_is_alt[i] = (g_func[2*i+1 -: 2] == MODE_ALT2);
    // R1: input reads pin level
    // R2: output reads stored bit
    assign g_rd[i] = g_is_out[i] ? g_data[i] : g_sync2[i];
    // R3: output drives data level
    assign g_out_d[i] = g_is_out[i] ? g_data[i] :
                        g_is_alt[i] ? alt2_out[i] : 1'b0;
    assign g_oe_d[i] = g_is_out[i] | (g_is_alt[i] & alt2_oe[i]);
  end

  // ***************************************************
  // interrupt event detect
  // ***************************************************
  logic [15:0] trig_type;
  logic [15:0] pol;
  logic [15:0] en;
  logic [IRQ_PINS-1:0] ev_a;
  logic [IRQ_PINS-1:0] ev_b;
  logic [15:0] ev_vec;

  for (genvar i = 0; i < IRQ_PINS; i++) begin : irq_pin
    logic lvl_a;
    logic old_a;
    logic lvl_b;
    logic old_b;
    // R10: port b polarity select
    // R11: port a polarity select
    assign lvl_a = a_sync2[i] ^ pol[PA_LSB+i];
    assign old_a = a_prev[i] ^ pol[PA_LSB+i];
    assign lvl_b = b_sync2[i] ^ pol[PB_LSB+i];
    assign old_b = b_prev[i] ^ pol[PB_LSB+i];
    // R9: port a level or edge
    // R17: port a enable gate
    assign ev_a[i] = en[PA_LSB+i] &
      (trig_type[PA_LSB+i] ? (lvl_a & ~old_a) : lvl_a);
    // R8: port b level or edge
    // R13: port b enable gate
    assign ev_b[i] = en[PB_LSB+i] &
      (trig_type[PB_LSB+i] ? (lvl_b & ~old_b) : lvl_b);
  end

  assign ev_vec = {ev_b, 4'h0, ev_a, 4'h0};

  // ***************************************************
  // register file
  // ***************************************************
  logic [15:0] stat;
  logic [15:0] armed;
  logic [15:0] mask;
  logic [15:0] clr;
  logic [G_PINS-1:0] next_g_data;
  logic [2*G_PINS-1:0] next_g_func;
  logic [15:0] next_trig_type;
  logic [15:0] next_pol;
  logic [15:0] next_en;
  logic [15:0] next_mask;
  logic [15:0] next_stat;
  logic [15:0] next_armed;
  logic [DATA_W-1:0] next_rd_data;
  logic next_irq;

  always_comb begin
    next_g_data = g_data;
    next_g_func = g_func;
    next_trig_type = trig_type;
    next_pol = pol;
    next_en = en;
    next_mask = mask;
    next_armed = armed;
    clr = '0;
    if (wr_stb) begin
      case (addr)
        OFS_G_DATA: next_g_data = wr_data[G_PINS-1:0];
        // R5: mode fields in low bits
        OFS_G_FUNC: next_g_func = wr_data[2*G_PINS-1:0];
        // R16: reserved bits stay zero
        OFS_TYPE: next_trig_type = wr_data & IRQ_BITS;
        OFS_POL: next_pol = wr_data & IRQ_BITS;
        OFS_EN: next_en = wr_data & IRQ_BITS;
        OFS_MASK: next_mask = wr_data & IRQ_BITS;
        OFS_STAT: begin
          // R18: one then zero clears
          next_armed = wr_data & IRQ_BITS;
          clr = armed & ~wr_data;
        end
        default: next_armed = armed;
      endcase
    end
    // R15: event sets, set beats clear
    next_stat = (stat & ~clr) | ev_vec;
    next_rd_data = '0;
    if (rd_stb) begin
      case (addr)
        OFS_G_DATA: next_rd_data = DATA_W'(g_rd);
        OFS_G_FUNC: next_rd_data = DATA_W'(g_func);
        OFS_TYPE: next_rd_data = trig_type;
        OFS_POL: next_rd_data = pol;
        OFS_EN: next_rd_data = en;
        OFS_STAT: next_rd_data = stat;
        OFS_MASK: next_rd_data = mask;
        default: next_rd_data = '0;
      endcase
    end
    // R19: merge unmasked status
    next_irq = |(stat & mask);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      g_data <= '0;
      g_func <= '0;
      trig_type <= RST_REG;
      pol <= RST_REG;
      en <= RST_REG;
      mask <= RST_REG;
      stat <= RST_REG;
      armed <= RST_REG;
      rd_data <= '0;
      irq <= 1'b0;
      port_g_pins_out <= '0;
      port_g_pins_oe <= '0;
      alt2_in <= '0;
    end else begin
      g_data <= next_g_data;
      g_func <= next_g_func;
      trig_type <= next_trig_type;
      pol <= next_pol;
      en <= next_en;
      mask <= next_mask;
      stat <= next_stat;
      armed <= next_armed;
      rd_data <= next_rd_data;
      irq <= next_irq;
      port_g_pins_out <= g_out_d;
      port_g_pins_oe <= g_oe_d;
      alt2_in <= g_sync2 & g_is_alt;
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  in_read_back_a: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (rd_stb && addr == OFS_G_DATA) |=>
    ((rd_data[G_PINS-1:0] & ~$past(g_is_out)) ==
     ($past(g_sync2) & ~$past(g_is_out))))
    else $error("input pin read wrong");

  out_read_back_a: assert property (@(posedge clk_sys) disable iff (rst) // R2
    (rd_stb && addr == OFS_G_DATA) |=>
    ((rd_data[G_PINS-1:0] & $past(g_is_out)) ==
     ($past(g_data) & $past(g_is_out))))
    else $error("output pin read wrong");

  out_drive_a: assert property (@(posedge clk_sys) disable iff (rst) // R3
    ##1 ((port_g_pins_out & $past(g_is_out)) ==
     ($past(g_data) & $past(g_is_out))))
    else $error("driven level wrong");

  mode_decode_a: assert property (@(posedge clk_sys) disable iff (rst) // R4
    ##1 (port_g_pins_oe ==
     ($past(g_is_out) | ($past(g_is_alt) & $past(alt2_oe)))))
    else $error("pin enable wrong");

  func_layout_a: assert property (@(posedge clk_sys) disable iff (rst) // R5
    (wr_stb && addr == OFS_G_FUNC) ##1 !wr_stb ##1
    (rd_stb && addr == OFS_G_FUNC)
    |=> rd_data == ($past(wr_data, 3) & 16'h03ff))
    else $error("function field lost");

  rsv_zero_a: assert property (@(posedge clk_sys) disable iff (rst) // R16
    ((trig_type | pol | en) & ~IRQ_BITS) == 16'h0000)
    else $error("reserved bits set");

  port_b_edge_a: assert property (@(posedge clk_sys) disable iff (rst) // R8
    (en[PB_LSB] && trig_type[PB_LSB] &&
     (b_sync2[0] ^ pol[PB_LSB]) == (b_prev[0] ^ pol[PB_LSB]))
    |-> !ev_vec[PB_LSB])
    else $error("edge fired without edge");

  port_a_level_a: assert property (@(posedge clk_sys) disable iff (rst) // R9
    (en[PA_LSB] && !trig_type[PA_LSB] &&
     (a_sync2[0] != pol[PA_LSB])) |=> stat[PA_LSB])
    else $error("level not recorded");

  gate_off_a: assert property (@(posedge clk_sys) disable iff (rst) // R13
    (ev_vec & ~en) == 16'h0000)
    else $error("disabled pin fired");

  event_sticky_a: assert property (@(posedge clk_sys) disable iff (rst) // R15
    (ev_vec != 16'h0000) |=>
    ((stat & $past(ev_vec)) == $past(ev_vec)))
    else $error("event not recorded");

  clear_seq_a: assert property (@(posedge clk_sys) disable iff (rst) // R18
    (wr_stb && addr == OFS_STAT) |=>
    ((stat & $past(armed) & ~$past(wr_data) & ~$past(ev_vec)) ==
     16'h0000))
    else $error("status not cleared");

  irq_merge_a: assert property (@(posedge clk_sys) disable iff (rst) // R19
    ((stat & mask) == 16'h0000) [*2] |-> !irq)
    else $error("irq without status");

endmodule

/* gpb_bank_bench.sv */
// gpb_bank_bench: self-checking bench for the pin bank
// assumes gpb_pins models the outside of port g
`timescale 1ns/100ps
module gpb_bank_bench
  import gpb_pkg::*;
;
  // ****
  // signals
  // ****
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic irq;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] rd_data;
  logic [4:0] g_in, g_out, g_oe, alt2_in;
  logic [4:0] g_ext = 5'h00;
  logic [4:0] alt2_out = 5'h0a;
  logic [4:0] alt2_oe = 5'h1f;
  logic [3:0] pa = 4'h0;
  logic [3:0] pb = 4'h0;
  int bad_count = 0;
  int checked = 0;

  always #5 clk_sys = ~clk_sys;

  gpb_bank i_gpb_bank (
    .clk_sys(clk_sys),
    .rst(rst),
    .addr(addr),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rd_data(rd_data),
    .port_g_pins_in(g_in),
    .port_g_pins_out(g_out),
    .port_g_pins_oe(g_oe),
    .alt2_out(alt2_out),
    .alt2_oe(alt2_oe),
    .alt2_in(alt2_in),
    .port_a_pins_in(pa),
    .port_b_pins_in(pb),
    .irq(irq)
  );

  gpb_pins i_gpb_pins (
    .g_out(g_out),
    .g_oe(g_oe),
    .g_ext(g_ext),
    .g_in(g_in)
  );

  // ****
  // shared tasks
  // ****
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    chk("rd_data", e, rd_data);
  endtask

  task automatic clr(input logic [15:0] v);
    wr(OFS_STAT, v);
    wr(OFS_STAT, 16'h0000);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_reset();
    logic [15:0] ofs [7];
    ofs = '{OFS_G_DATA, OFS_G_FUNC, OFS_TYPE, OFS_POL, OFS_EN,
            OFS_STAT, OFS_MASK};
    for (int i = 0; i < 7; i++) begin
      rd(ofs[i], 16'h0000);
    end
    // unmapped write kept off the reserved spans
    wr(16'h0c2e, 16'hffff);
    rd(16'h0c2e, 16'h0000);
    rd(OFS_EN, 16'h0000);
    chk("port_g_pins_oe", 16'h0000, {11'h000, g_oe});
    chk("irq", 16'h0000, {15'h0000, irq});
  endtask

  task automatic t_port_g();
    logic [1:0] m;
    logic [15:0] rd_e;
    wr(OFS_G_DATA, 16'h0013);
    g_ext <= 5'h0c;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      wr(OFS_G_FUNC, {6'h00, {5{m}}});
      wt(4);
      chk("port_g_pins_oe", m[1] ? 16'h001f : 16'h0000,
          {11'h000, g_oe});
      if (m[1]) begin
        chk("port_g_pins_out", m[0] ? 16'h000a : 16'h0013,
            {11'h000, g_out});
      end
      chk("alt2_in", m == MODE_ALT2 ? 16'h000a : 16'h0000,
          {11'h000, alt2_in});
      rd_e = m == MODE_OUT ? 16'h0013 : 16'h000c;
      rd(OFS_G_DATA, m == MODE_ALT2 ? 16'h000a : rd_e);
    end
    @(posedge clk_sys);
    alt2_oe <= 5'h03;
    wt(4);
    chk("port_g_pins_oe", 16'h0003, {11'h000, g_oe});
    chk("alt2_in", 16'h000e, {11'h000, alt2_in});
    wr(OFS_G_FUNC, 16'h0280);
    wt(4);
    chk("port_g_pins_oe", 16'h0018, {11'h000, g_oe});
    rd(OFS_G_DATA, 16'h0014);
    wr(OFS_G_FUNC, 16'hffff);
    rd(OFS_G_FUNC, 16'h03ff);
    wt(1);
    chk("rd_data", 16'h0000, rd_data);
    wr(OFS_G_FUNC, 16'h0000);
  endtask

  task automatic t_edge();
    wr(OFS_TYPE, 16'h0010);
    wr(OFS_POL, 16'h0000);
    wr(OFS_EN, 16'h0010);
    wr(OFS_MASK, 16'h0010);
    wt(4);
    rd(OFS_STAT, 16'h0000);
    @(posedge clk_sys);
    pa <= 4'h1;
    wt(5);
    rd(OFS_STAT, 16'h0010);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(OFS_STAT, 16'h0010);
    rd(OFS_STAT, 16'h0010);
    wr(OFS_STAT, 16'h0000);
    wt(2);
    rd(OFS_STAT, 16'h0000);
    chk("irq", 16'h0000, {15'h0000, irq});
    wr(OFS_POL, 16'h0010);
    clr(16'h0010);
    pa <= 4'h0;
    wt(5);
    rd(OFS_STAT, 16'h0010);
    clr(16'h0010);
  endtask

  task automatic t_level();
    wr(OFS_EN, 16'h0000);
    clr(16'hf0f0);
    wr(OFS_TYPE, 16'h0000);
    wr(OFS_POL, 16'hf000);
    wr(OFS_EN, 16'h8000);
    wr(OFS_MASK, 16'hf0f0);
    wt(4);
    rd(OFS_STAT, 16'h8000);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(OFS_MASK, 16'h0000);
    wt(2);
    chk("irq", 16'h0000, {15'h0000, irq});
    clr(16'h8000);
    rd(OFS_STAT, 16'h8000);
    @(posedge clk_sys);
    pb <= 4'hf;
    pa <= 4'hb;
    wr(OFS_EN, 16'h80f0);
    wt(3);
    clr(16'hf0f0);
    wt(4);
    rd(OFS_STAT, 16'h00b0);
  endtask

  task automatic t_b_edge();
    wr(OFS_EN, 16'h0000);
    clr(16'hf0f0);
    wr(OFS_TYPE, 16'hf000);
    wr(OFS_POL, 16'h8000);
    wr(OFS_EN, 16'hf000);
    wr(OFS_MASK, 16'h8000);
    wt(4);
    rd(OFS_STAT, 16'h0000);
    @(posedge clk_sys);
    pb <= 4'h7;
    wt(5);
    rd(OFS_STAT, 16'h8000);
    chk("irq", 16'h0001, {15'h0000, irq});
    clr(16'h8000);
    rd(OFS_STAT, 16'h0000);
    chk("irq", 16'h0000, {15'h0000, irq});
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_port_g();
    t_edge();
    t_level();
    t_b_edge();
    end_sim();
  end

  initial begin
    #20000;
    bad_count++;
    end_sim();
  end
endmodule

/* gpb_pins.sv */
// gpb_pins: outside circuitry on the port g pads
// assumes the bench sets what outside drivers put on undriven pads
`timescale 1ns/100ps
module gpb_pins (
  // from the bank
  input wire logic [4:0] g_out,
  input wire logic [4:0] g_oe,
  // outside drivers
  input wire logic [4:0] g_ext,
  // pad levels back to the bank
  output logic [4:0] g_in
);
  // ****
  // pad resolution
  // ****
  // driven pads show the bank level
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      g_in[i] = g_oe[i] ? g_out[i] : g_ext[i];
    end
  end
endmodule

/* gpb_pkg.sv */
// gpb_pkg: offsets, field layouts and reset values of the pin bank
// assumes a 16-bit register port with byte offsets as printed
package gpb_pkg;

  // ***************************************************
  // bus widths
  // ***************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // ***************************************************
  // register offsets
  // ***************************************************
  localparam logic [15:0] OFS_G_DATA = 16'h0c18;
  localparam logic [15:0] OFS_G_FUNC = 16'h0c1a;
  localparam logic [15:0] OFS_TYPE = 16'h0c24;
  localparam logic [15:0] OFS_POL = 16'h0c26;
  localparam logic [15:0] OFS_EN = 16'h0c28;
  localparam logic [15:0] OFS_STAT = 16'h0c2a;
  localparam logic [15:0] OFS_MASK = 16'h0c2c;

  // ***************************************************
  // fields and modes
  // ***************************************************
  localparam int PA_LSB = 4;
  localparam int PB_LSB = 12;
  localparam logic [1:0] MODE_IN = 2'h0;
  localparam logic [1:0] MODE_RSV = 2'h1;
  localparam logic [1:0] MODE_OUT = 2'h2;
  localparam logic [1:0] MODE_ALT2 = 2'h3;
  localparam logic [15:0] IRQ_BITS = 16'hf0f0;

  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [15:0] RST_REG = 16'h0000;

endpackage
